// File: include/dfam_defines.svh
// Offsets, field positions, reset values and timing figures of the drive fault and alarm manager.
// Assumes a 10 MHz system clock and a 32-bit Avalon-MM register port with byte addresses.
`ifndef DFAM_DEFINES_SVH
`define DFAM_DEFINES_SVH

// Register byte offsets.
`define DFAM_REG_CTRL       6'h00
`define DFAM_REG_STATUS     6'h04
`define DFAM_REG_CODE       6'h08
`define DFAM_REG_CONTACT    6'h0c
`define DFAM_REG_GAIN1      6'h10
`define DFAM_REG_BIAS1      6'h14
`define DFAM_REG_GAIN2      6'h18
`define DFAM_REG_BIAS2      6'h1c
`define DFAM_REG_IN2CFG     6'h20
`define DFAM_REG_FREQ       6'h24
`define DFAM_REG_LOCREF     6'h28

// Control register fields.
`define DFAM_CTRL_RUN       0
`define DFAM_CTRL_LOCAL     1
`define DFAM_CTRL_TUNE      2
`define DFAM_CTRL_OPTSRC    3
`define DFAM_CTRL_STOP_LO   4
`define DFAM_CTRL_STOP_HI   5
`define DFAM_CTRL_FRESET    8
`define DFAM_CTRL_RESET     6'h00

// Contact function codes and reset selections.
`define DFAM_FUNC_FAULT     8'h0e
`define DFAM_FUNC_MINOR     8'h10
`define DFAM_CONTACT_RESET  24'h0f0f0f

// Second input level and function codes.
`define DFAM_LVL_LIVE_ZERO  2'h2
`define DFAM_LVL_ZERO_20MA  2'h3
`define DFAM_IN2_FUNC_ADD   2'h0
`define DFAM_IN2_FUNC_NONE  2'h1
`define DFAM_IN2_RESET      4'h4

// Scaling figures: 12-bit converter, live zero at one fifth of full scale.
`define DFAM_ADC_LIVE_ZERO  12'h333
`define DFAM_ADC_FULL       12'hfff
`define DFAM_GAIN_RESET     16'h1770
`define DFAM_BIAS_RESET     16'h0000

// Display codes.
`define DFAM_CODE_NONE      8'h00
`define DFAM_CODE_FAULT     8'h10
`define DFAM_CODE_OPER      8'h40
`define DFAM_CODE_TUNE      8'h50
`define DFAM_CODE_MINOR     8'h60
`define DFAM_CODE_ALARM     8'h70

// Flash timing of the alarm indicator.
`define DFAM_BLINK_HALF_MS  500
`define DFAM_CLK_KHZ        10000

`endif

// File: include/dfam_pkg.sv
// Types shared by the drive fault and alarm manager modules.
// Assumes dfam_defines.svh holds the numeric constants.
package dfam_pkg;

	// Stop behaviour requested from the power stage.
	typedef enum logic [1:0] {
		DFAM_STOP_COAST,
		DFAM_STOP_RAMP,
		DFAM_STOP_DCBRAKE
	} dfam_stop_t;

	// Alarm indicator drive modes.
	typedef enum logic [1:0] {
		DFAM_IND_OFF,
		DFAM_IND_STEADY,
		DFAM_IND_FLASH
	} dfam_ind_t;

	// Gain and bias of one analog input, both frequency references.
	typedef struct packed {
		logic [15:0] gain;
		logic [15:0] bias;
	} dfam_scale_t;

	// Condition summary of the block.
	typedef struct packed {
		logic fault;
		logic minor;
		logic alarm;
		logic oper_err;
		logic tune_err;
	} dfam_cond_t;

endpackage : dfam_pkg

// File: rtl/dfam_sync.sv
// Three-stage input synchroniser with agreement filter for asynchronous pins.
// Assumes the input is quasi-static relative to the 100 ns system clock.
`timescale 1ns/1ns
`include "dfam_defines.svh"
module dfam_sync import dfam_pkg::*; #(
	parameter int W = 1
) (
	input  wire logic         i_sys_clk,
	input  wire logic         i_rst,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);

	logic [W-1:0] stage1; // Metastability catcher, read only by stage2.
	logic [W-1:0] stage2; // Second stage.
	logic [W-1:0] stage3; // Third stage.

	// Shift chain; a bit is accepted only once stages two and three agree.
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
			o_sync <= '0;
		end else begin
			stage1 <= i_async;
			stage2 <= stage1;
			stage3 <= stage2;
			o_sync <= (stage2 & stage3) | (o_sync & (stage2 | stage3));
		end
	end

endmodule : dfam_sync

// File: rtl/dfam_scaler.sv
// Linear gain and bias scaling of one 12-bit analog input to a frequency reference.
// Assumes a converter code that is already in the system clock domain.
`timescale 1ns/1ns
`include "dfam_defines.svh"
module dfam_scaler import dfam_pkg::*; (
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst,
	input  wire logic [11:0] i_sample,
	input  wire logic        i_live_zero,
	input  wire dfam_scale_t i_scale,
	output logic      [15:0] o_ref
);

	logic        [12:0] norm;  // Input normalised to a 0..4095 span.
	logic signed [16:0] span;  // Gain minus bias.
	logic signed [34:0] prod;  // Span times normalised input, wide enough for a full-range gain.
	logic signed [17:0] sum;   // Bias plus scaled span.

	always_comb begin
		norm = {1'b0, i_sample};
		if (i_live_zero) begin
			// Below the live zero the reference pins at bias; the span is stretched by five quarters.
			if (i_sample < `DFAM_ADC_LIVE_ZERO)
				norm = 13'h0000;
			else
				norm = 13'((({3'b000, i_sample} - {3'b000, `DFAM_ADC_LIVE_ZERO}) * 15'h0005) >> 2);
		end
		span = $signed({1'b0, i_scale.gain}) - $signed({1'b0, i_scale.bias});
		prod = span * $signed({1'b0, norm, 4'h0});
		sum  = $signed({2'b00, i_scale.bias}) + 18'(prod >>> 16);
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst)
			o_ref <= 16'h0000;
		else if (sum < 0)
			o_ref <= 16'h0000;
		else
			o_ref <= sum[15:0];
	end

endmodule : dfam_scaler

// File: rtl/dfam_top.sv
// Drive fault, alarm and error manager with analog frequency reference scaling.
// Assumes asynchronous condition pins, converter samples in the system clock domain,
// and an Avalon-MM master that holds each request until waitrequest is low.
//
// Overview of operation
// - fault cuts output, coast unless configured
// - fault-function contacts close during fault
// - fault latched, no run until reset
// - alarm or minor: code, flashing indicator
// - minor-function contacts close, alarms do not
// - alarms and minor faults self-clear
// - conflicting settings raise an operation error
// - operation error displays, blocks motor only
// - tuning error: display, coast, retune
// - second input codes 2,3 are current
// - terminal control means remote, indicator off
// - gain sets reference at maximum signal
// - bias sets reference at minimum signal
//
// Register access over Avalon-MM and the register offsets were left to the implementer.
`timescale 1ns/1ns
`include "dfam_defines.svh"
module dfam_top import dfam_pkg::*; #(
	parameter int BLINK_CYCLES = `DFAM_BLINK_HALF_MS * `DFAM_CLK_KHZ
) (
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst,
	input  wire logic [5:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	output logic      [31:0] o_avs_readdata,
	output logic             o_avs_waitrequest,
	input  wire logic [7:0]  i_fault_cause,
	input  wire logic [3:0]  i_minor_cause,
	input  wire logic [3:0]  i_alarm_cause,
	input  wire logic        i_tune_fail,
	input  wire logic        i_term_run,
	input  wire logic        i_option_fitted,
	input  wire logic        i_voltage_current_switch,
	input  wire logic [11:0] i_voltage_analog_input,
	input  wire logic [11:0] i_current_analog_input,
	output logic      [7:0]  o_display_code,
	output logic             o_alarm_indicator,
	output logic             o_local_remote_indicator,
	output logic             o_drive_run,
	output dfam_stop_t       o_stop_kind,
	output logic      [2:0]  o_contact_out,
	output logic      [15:0] o_freq_ref,
	output logic             o_tuning_active
);

	// Software-visible settings.
	logic [5:0]  ctrl;         // Run, local, tune, option source and stop method.
	logic [23:0] contact_sel;  // One contact_output_function_select byte per contact.
	dfam_scale_t scale1;       // first_input_gain and first_input_bias.
	dfam_scale_t scale2;       // second_input_gain and second_input_bias.
	logic [1:0]  second_input_level_select;    // Signal level of the current input.
	logic [1:0]  second_input_function_select; // Use of the current input.
	logic [15:0] local_ref;    // Operator reference used in local mode.

	// Bus handshake.
	logic        acked;        // Second cycle of an access, where it completes.
	logic        wr_take;      // A write takes effect this cycle.
	logic        fault_reset;  // Software fault reset pulse.
	logic        tune_restart; // Software restarts auto-tuning.

	// Synchronised pins.
	logic [7:0]  fault_s;      // Fault causes.
	logic [3:0]  minor_s;      // Minor fault causes.
	logic [3:0]  alarm_s;      // Alarm causes.
	logic [3:0]  misc_s;       // Tune fail, terminal run, option fitted, switch.

	// Condition state.
	logic [7:0]  fault_latch;  // Latched faults, one per cause.
	logic        tune_err;     // Latched tuning error.
	logic        oper_err;     // Settings conflict present.
	logic        next_oper_err;// Conflict evaluated this cycle.
	dfam_cond_t  cond;         // Summary of all classes.
	logic [7:0]  next_code;    // Display code by priority.
	dfam_ind_t   ind_mode;     // Indicator drive mode.
	logic [22:0] blink_cnt;    // Flash half-period counter.
	logic        blink_phase;  // Current flash level.

	// Reference path.
	logic [15:0] ref1;         // Scaled voltage input.
	logic [15:0] ref2;         // Scaled current input.
	logic [16:0] ref_sum;      // Sum before saturation.
	logic        in2_current;  // Second input set for a current range.
	logic        run_src;      // Run request from the selected source.

	// Every condition and mode pin from outside passes the three-stage filter; bus and converter inputs do not.
	dfam_sync #(.W(8)) u_sync_fault (
		.i_sys_clk (i_sys_clk),
		.i_rst     (i_rst),
		.i_async   (i_fault_cause),
		.o_sync    (fault_s)
	);
	dfam_sync #(.W(4)) u_sync_minor (
		.i_sys_clk (i_sys_clk),
		.i_rst     (i_rst),
		.i_async   (i_minor_cause),
		.o_sync    (minor_s)
	);
	dfam_sync #(.W(4)) u_sync_alarm (
		.i_sys_clk (i_sys_clk),
		.i_rst     (i_rst),
		.i_async   (i_alarm_cause),
		.o_sync    (alarm_s)
	);
	dfam_sync #(.W(4)) u_sync_misc (
		.i_sys_clk (i_sys_clk),
		.i_rst     (i_rst),
		.i_async   ({i_voltage_current_switch, i_option_fitted, i_term_run, i_tune_fail}),
		.o_sync    (misc_s)
	);

	// One wait state: waitrequest is high in the first cycle of each access.
	assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~acked;
	assign wr_take           = i_avs_write & acked;
	assign fault_reset       = wr_take && (i_avs_address == `DFAM_REG_CTRL) && i_avs_writedata[`DFAM_CTRL_FRESET];
	assign tune_restart      = wr_take && (i_avs_address == `DFAM_REG_CTRL) && i_avs_writedata[`DFAM_CTRL_TUNE];

	// Access phase tracking; acked drops after the completing cycle.
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst)
			acked <= 1'b0;
		else
			acked <= (i_avs_read | i_avs_write) & ~acked;
	end

	// Register writes; unmapped offsets are ignored.
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			ctrl                         <= `DFAM_CTRL_RESET;
			contact_sel                  <= `DFAM_CONTACT_RESET;
			scale1                       <= {`DFAM_GAIN_RESET, `DFAM_BIAS_RESET};
			scale2                       <= {`DFAM_GAIN_RESET, `DFAM_BIAS_RESET};
			second_input_level_select    <= 2'(`DFAM_IN2_RESET);
			second_input_function_select <= `DFAM_IN2_FUNC_NONE;
			local_ref                    <= 16'h0000;
		end else if (wr_take) begin
			case (i_avs_address)
				`DFAM_REG_CTRL:    ctrl        <= i_avs_writedata[5:0];
				`DFAM_REG_CONTACT: contact_sel <= i_avs_writedata[23:0];
				`DFAM_REG_GAIN1:   scale1.gain <= i_avs_writedata[15:0];
				`DFAM_REG_BIAS1:   scale1.bias <= i_avs_writedata[15:0];
				`DFAM_REG_GAIN2:   scale2.gain <= i_avs_writedata[15:0];
				`DFAM_REG_BIAS2:   scale2.bias <= i_avs_writedata[15:0];
				`DFAM_REG_IN2CFG: begin
					second_input_level_select    <= i_avs_writedata[1:0];
					second_input_function_select <= i_avs_writedata[3:2];
				end
				`DFAM_REG_LOCREF:  local_ref   <= i_avs_writedata[15:0];
				default: begin
					// Read-only or unmapped: nothing changes.
				end
			endcase
		end
	end

	// Read data is loaded in the wait cycle so it stands when waitrequest drops.
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_avs_readdata <= 32'h00000000;
		end else if (i_avs_read & ~acked) begin
			case (i_avs_address)
				`DFAM_REG_CTRL:    o_avs_readdata <= {26'h0, ctrl};
				`DFAM_REG_STATUS:  o_avs_readdata <= {25'h0, o_alarm_indicator, o_drive_run, cond};
				`DFAM_REG_CODE:    o_avs_readdata <= {16'h0, fault_latch, o_display_code};
				`DFAM_REG_CONTACT: o_avs_readdata <= {8'h0, contact_sel};
				`DFAM_REG_GAIN1:   o_avs_readdata <= {16'h0, scale1.gain};
				`DFAM_REG_BIAS1:   o_avs_readdata <= {16'h0, scale1.bias};
				`DFAM_REG_GAIN2:   o_avs_readdata <= {16'h0, scale2.gain};
				`DFAM_REG_BIAS2:   o_avs_readdata <= {16'h0, scale2.bias};
				`DFAM_REG_IN2CFG:  o_avs_readdata <= {28'h0, second_input_function_select, second_input_level_select};
				`DFAM_REG_FREQ:    o_avs_readdata <= {16'h0, o_freq_ref};
				`DFAM_REG_LOCREF:  o_avs_readdata <= {16'h0, local_ref};
				default:           o_avs_readdata <= 32'h00000000;
			endcase
		end
	end

	// latch until reset
	// A cause still present at the reset pulse re-latches, so a new event is never lost.
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst)
			fault_latch <= 8'h00;
		else
			fault_latch <= (fault_latch & {8{~fault_reset}}) | fault_s;
	end

	// tuning error latch
	// Set only while auto-tuning runs; a new tuning start clears it, the set winning.
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst)
			tune_err <= 1'b0;
		else
			tune_err <= (tune_err & ~tune_restart) | (ctrl[`DFAM_CTRL_TUNE] & misc_s[0]);
	end

	// settings conflict check
	// A current range against the switch in voltage, or the reverse, is a hardware mismatch.
	always_comb begin
		next_oper_err = 1'b0;
		if (in2_current != misc_s[3])
			next_oper_err = 1'b1;
		if (ctrl[`DFAM_CTRL_OPTSRC] & ~misc_s[2])
			next_oper_err = 1'b1;
		if (second_input_function_select > `DFAM_IN2_FUNC_NONE)
			next_oper_err = 1'b1;
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst)
			oper_err <= 1'b0;
		else
			oper_err <= next_oper_err;
	end

	// no latch on alarms
	// Minor faults and alarms follow their causes directly.
	assign cond = '{fault: |fault_latch, minor: |minor_s, alarm: |alarm_s,
		oper_err: oper_err, tune_err: tune_err};

	// fault code first
	// Priority: faults, operation error, tuning error, minor fault, alarm.
	always_comb begin
		next_code = `DFAM_CODE_NONE;
		if (cond.alarm)
			next_code = `DFAM_CODE_ALARM;
		if (cond.minor)
			next_code = `DFAM_CODE_MINOR;
		if (cond.tune_err)
			next_code = `DFAM_CODE_TUNE;
		if (cond.oper_err)
			next_code = `DFAM_CODE_OPER;
		for (int i = 7; i >= 0; i--) begin
			if (fault_latch[i])
				next_code = `DFAM_CODE_FAULT + 8'(i);
		end
	end

	// Display register.
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst)
			o_display_code <= `DFAM_CODE_NONE;
		else
			o_display_code <= next_code;
	end

	assign ind_mode = cond.fault ? DFAM_IND_STEADY :
		((cond.minor | cond.alarm) ? DFAM_IND_FLASH : DFAM_IND_OFF);

	// Flash timebase; it restarts whenever flashing is not wanted so the first half is whole.
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			blink_cnt   <= 23'h000000;
			blink_phase <= 1'b0;
		end else if (ind_mode != DFAM_IND_FLASH) begin
			blink_cnt   <= 23'h000000;
			blink_phase <= 1'b1;
		end else if (blink_cnt == 23'(BLINK_CYCLES - 1)) begin
			blink_cnt   <= 23'h000000;
			blink_phase <= ~blink_phase;
		end else begin
			blink_cnt   <= blink_cnt + 23'h000001;
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_alarm_indicator <= 1'b0;
		end else begin
			case (ind_mode)
				DFAM_IND_STEADY: o_alarm_indicator <= 1'b1;
				DFAM_IND_FLASH:  o_alarm_indicator <= blink_phase;
				DFAM_IND_OFF:    o_alarm_indicator <= 1'b0;
				default:         o_alarm_indicator <= 1'b0;
			endcase
		end
	end

	// minor contact only
	// Operation and tuning errors never reach the contacts.
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_contact_out <= 3'h0;
		end else begin
			for (int c = 0; c < 3; c++) begin
				case (contact_sel[c*8 +: 8])
					`DFAM_FUNC_FAULT: o_contact_out[c] <= cond.fault;
					`DFAM_FUNC_MINOR: o_contact_out[c] <= cond.minor;
					default:          o_contact_out[c] <= 1'b0;
				endcase
			end
		end
	end

	assign run_src = ctrl[`DFAM_CTRL_LOCAL] ? ctrl[`DFAM_CTRL_RUN] : misc_s[1];

	// cut output on fault
	// Operation and tuning errors also inhibit running; the run request must be held.
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst)
			o_drive_run <= 1'b0;
		else
			o_drive_run <= run_src & ~cond.fault & ~cond.oper_err & ~cond.tune_err;
	end

	// coast on tuning error
	// Faults use the configured method, coast being its reset value.
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_stop_kind <= DFAM_STOP_COAST;
		end else if (cond.tune_err) begin
			o_stop_kind <= DFAM_STOP_COAST;
		end else begin
			case (ctrl[`DFAM_CTRL_STOP_HI:`DFAM_CTRL_STOP_LO])
				2'h1:    o_stop_kind <= DFAM_STOP_RAMP;
				2'h2:    o_stop_kind <= DFAM_STOP_DCBRAKE;
				default: o_stop_kind <= DFAM_STOP_COAST;
			endcase
		end
	end

	// Mode indicators.
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_local_remote_indicator <= 1'b0;
			o_tuning_active          <= 1'b0;
		end else begin
			o_local_remote_indicator <= ctrl[`DFAM_CTRL_LOCAL];
			o_tuning_active          <= ctrl[`DFAM_CTRL_TUNE] & ~tune_err;
		end
	end

	// current level codes
	// Codes 0 and 1 both mean the voltage range; only code 2 has a live zero.
	assign in2_current = (second_input_level_select == `DFAM_LVL_LIVE_ZERO) ||
		(second_input_level_select == `DFAM_LVL_ZERO_20MA);

	dfam_scaler u_scale1 (
		.i_sys_clk   (i_sys_clk),
		.i_rst       (i_rst),
		.i_sample    (i_voltage_analog_input),
		.i_live_zero (1'b0),
		.i_scale     (scale1),
		.o_ref       (ref1)
	);
	dfam_scaler u_scale2 (
		.i_sys_clk   (i_sys_clk),
		.i_rst       (i_rst),
		.i_sample    (i_current_analog_input),
		.i_live_zero (second_input_level_select == `DFAM_LVL_LIVE_ZERO),
		.i_scale     (scale2),
		.o_ref       (ref2)
	);

	// The second input adds to the first when so selected; the sum saturates.
	assign ref_sum = (second_input_function_select == `DFAM_IN2_FUNC_ADD) ?
		({1'b0, ref1} + {1'b0, ref2}) : {1'b0, ref1};

	// Reference output: operator value in local mode, terminals in remote.
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst)
			o_freq_ref <= 16'h0000;
		else if (ctrl[`DFAM_CTRL_LOCAL])
			o_freq_ref <= local_ref;
		else if (ref_sum[16])
			o_freq_ref <= 16'hffff;
		else
			o_freq_ref <= ref_sum[15:0];
	end

endmodule : dfam_top

// File: sim/dfam_top_asserts.sv
// Concurrent checks on the ports of the drive fault and alarm manager.
// Assumes one clock domain and a bench that keeps the register bus contract.
`timescale 1ns/1ns
module dfam_top_asserts import dfam_pkg::*; #(
	parameter int BLINK_CYCLES = 4
) (
	input wire logic       i_sys_clk,
	input wire logic       i_rst,
	input wire logic       i_avs_read,
	input wire logic       i_avs_write,
	input wire logic       o_avs_waitrequest,
	input wire logic [7:0] o_display_code,
	input wire logic       o_alarm_indicator,
	input wire logic       o_drive_run,
	input wire dfam_stop_t o_stop_kind
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	logic [31:0] hi_run; // Length of the current lit stretch of the indicator.
	// Counting the lit stretch lets one check cover any blink period.
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			hi_run <= 32'h0;
		end else if (o_alarm_indicator) begin
			hi_run <= hi_run + 32'h1;
		end else begin
			hi_run <= 32'h0;
		end
	end
	chk_fault_steady: assert property (o_display_code[7:4] == 4'h1 |-> o_alarm_indicator)
		else $error("indicator dark while a fault is shown");
	chk_fault_norun: assert property (o_display_code[7:4] == 4'h1 |-> !o_drive_run)
		else $error("drive runs while a fault is shown");
	chk_fault_latch: assert property (o_display_code[7:4] == 4'h1 && !i_avs_write && !$past(i_avs_write)
		&& !$past(i_avs_write, 2) |=> o_display_code[7:4] == 4'h1)
		else $error("fault cleared without a reset write");
	chk_flash_half: assert property ($fell(o_alarm_indicator) && (o_display_code inside {8'h60, 8'h70})
		|-> hi_run == BLINK_CYCLES)
		else $error("flash half period wrong");
	chk_oper_norun: assert property (o_display_code == 8'h40 |-> !o_drive_run)
		else $error("drive runs during an operation error");
	chk_tune_coast: assert property (o_display_code == 8'h50 |-> o_stop_kind == DFAM_STOP_COAST && !o_drive_run)
		else $error("tuning error without coasting");
	chk_wait_first: assert property ($rose(i_avs_read || i_avs_write) |-> o_avs_waitrequest)
		else $error("waitrequest low in first access cycle");
	chk_wait_once: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
		else $error("waitrequest high for more than one cycle");
	chk_reset_quiet: assert property ($fell(i_rst) |-> o_display_code == 8'h00 && !o_drive_run)
		else $error("outputs active after reset");
	cov_fault: cover property (o_display_code == 8'h12);
	cov_flash: cover property ($fell(o_alarm_indicator) && o_display_code == 8'h70);
	cov_tune: cover property (o_display_code == 8'h50);
endmodule : dfam_top_asserts

bind dfam_top dfam_top_asserts #(.BLINK_CYCLES(BLINK_CYCLES)) dfam_top_asserts_inst (
	.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
	.o_avs_waitrequest(o_avs_waitrequest), .o_display_code(o_display_code),
	.o_alarm_indicator(o_alarm_indicator), .o_drive_run(o_drive_run), .o_stop_kind(o_stop_kind));

// File: sim/dfam_panel_model.sv
// Operator panel model that watches the alarm indicator lamp.
// Assumes the lamp is sampled on the system clock.
`timescale 1ns/1ns
module dfam_panel_model (
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst,
	input  wire logic        i_alarm_indicator,
	output logic      [15:0] o_toggles
);
	logic last; // Lamp level seen at the previous edge.
	// A steady lamp adds nothing, so a flash shows as a rising count.
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			last      <= 1'b0;
			o_toggles <= 16'h0;
		end else begin
			last <= i_alarm_indicator;
			if (last != i_alarm_indicator) begin
				o_toggles <= o_toggles + 16'h1;
			end
		end
	end
endmodule : dfam_panel_model

// File: sim/testbench.sv
// Self-checking bench for the drive fault and alarm manager.
// Assumes a two-cycle Avalon-MM access and a four-cycle blink half period.
`timescale 1ns/1ns
`include "dfam_defines.svh"
module testbench import dfam_pkg::*; ;
	logic        clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, tf = 1'b0, tr = 1'b0, opt = 1'b0, vcs = 1'b0;
	logic [5:0]  adr = 6'h0;
	logic [31:0] wd = 32'h0, rdata;
	logic [7:0]  fc = 8'h0, code;
	logic [3:0]  mc = 4'h0, ac = 4'h0;
	logic [11:0] va = 12'h0, ca = 12'h0;
	logic        wreq, ind, lri, run, tact;
	logic [2:0]  cont;
	logic [15:0] fref, tog, t0;
	dfam_stop_t  stop;
	int          n_fail = 0, num_checks = 0;
	always #50 clk = ~clk;
	dfam_top #(.BLINK_CYCLES(4)) dfam_top_inst (.i_sys_clk(clk), .i_rst(rst), .i_avs_address(adr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdata),
		.o_avs_waitrequest(wreq), .i_fault_cause(fc), .i_minor_cause(mc), .i_alarm_cause(ac),
		.i_tune_fail(tf), .i_term_run(tr), .i_option_fitted(opt), .i_voltage_current_switch(vcs),
		.i_voltage_analog_input(va), .i_current_analog_input(ca), .o_display_code(code),
		.o_alarm_indicator(ind), .o_local_remote_indicator(lri), .o_drive_run(run), .o_stop_kind(stop),
		.o_contact_out(cont), .o_freq_ref(fref), .o_tuning_active(tact));
	dfam_panel_model dfam_panel_model_inst (.i_sys_clk(clk), .i_rst(rst), .i_alarm_indicator(ind), .o_toggles(tog));
	// Prints the verdict once and ends the run.
	task conclude;
		if (n_fail == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : conclude
	// Compares one value, unknowns count as mismatches.
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : cmp
	// One Avalon access; the request stands until waitrequest is sampled low.
	task bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
		int k;
		@(posedge clk);
		adr <= a;
		wd  <= d;
		wr  <= w;
		rd  <= ~w;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (wreq !== 1'b0 && k < 50);
		q = rdata;
		if (k >= 50) cmp(1'b1, 1'b0);
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus
	task wreg(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wreg
	task rchk(input logic [5:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		cmp(q, e);
	endtask : rchk
	// Lets a pin change pass the synchroniser and reach the outputs.
	task settle;
		repeat (10) @(posedge clk);
	endtask : settle
	// Reset values and an unmapped address.
	task t_reset;
		cmp(run, 1'b0);
		rchk(`DFAM_REG_CTRL, 32'h0);
		rchk(`DFAM_REG_CONTACT, 32'h000f0f0f);
		rchk(`DFAM_REG_GAIN1, 32'h00001770);
		rchk(`DFAM_REG_BIAS2, 32'h0);
		rchk(`DFAM_REG_IN2CFG, 32'h4);
		wreg(6'h3c, 32'h5a5a5a5a);
		rchk(6'h3c, 32'h0);
	endtask : t_reset
	// A latched fault with two causes, held past its cause, then reset.
	task t_fault;
		wreg(`DFAM_REG_CONTACT, 32'h000f100e);
		wreg(`DFAM_REG_CTRL, 32'h3);
		settle;
		cmp(run, 1'b1);
		@(posedge clk) fc <= 8'h24;
		settle;
		t0 = tog;
		cmp(code, 8'h12);
		cmp(stop, DFAM_STOP_COAST);
		cmp(cont, 3'b001);
		@(posedge clk) fc <= 8'h00;
		settle;
		cmp({code, ind, run}, {8'h12, 1'b1, 1'b0});
		cmp(tog, t0);
		wreg(`DFAM_REG_CTRL, 32'h113);
		settle;
		cmp({code, cont, run}, {8'h00, 3'b000, 1'b1});
		cmp(stop, DFAM_STOP_RAMP);
	endtask : t_fault
	// Alarm then minor fault while running, both clear by themselves.
	task t_minor;
		@(posedge clk) ac <= 4'h1;
		settle;
		cmp({code, cont, run}, {8'h70, 3'b000, 1'b1});
		t0 = tog;
		repeat (20) @(posedge clk);
		cmp(tog - t0, 16'h5);
		@(posedge clk) begin
			ac <= 4'h0;
			mc <= 4'h2;
		end
		settle;
		cmp({code, cont, run}, {8'h60, 3'b010, 1'b1});
		@(posedge clk) mc <= 4'h0;
		settle;
		cmp({code, cont, ind}, {8'h00, 3'b000, 1'b0});
	endtask : t_minor
	// Current level codes against the switch, and the option source without a card.
	task t_oper;
		for (int lv = 2; lv <= 3; lv++) begin
			wreg(`DFAM_REG_IN2CFG, lv);
			settle;
			cmp({code, cont, run}, {8'h40, 3'b000, 1'b0});
			@(posedge clk) vcs <= 1'b1;
			settle;
			cmp({code, run}, {8'h00, 1'b1});
			@(posedge clk) vcs <= 1'b0;
		end
		wreg(`DFAM_REG_IN2CFG, 32'h4);
		wreg(`DFAM_REG_CTRL, 32'hb);
		settle;
		cmp({code, run}, {8'h40, 1'b0});
		@(posedge clk) opt <= 1'b1;
		settle;
		cmp(code, 8'h00);
		wreg(`DFAM_REG_CTRL, 32'h3);
	endtask : t_oper
	// A tuning failure coasts the motor; a repeated tuning clears it.
	task t_tune;
		wreg(`DFAM_REG_CTRL, 32'h17);
		settle;
		cmp(tact, 1'b1);
		@(posedge clk) tf <= 1'b1;
		settle;
		cmp({code, cont, run, tact}, {8'h50, 3'b000, 1'b0, 1'b0});
		cmp(stop, DFAM_STOP_COAST);
		@(posedge clk) tf <= 1'b0;
		settle;
		wreg(`DFAM_REG_CTRL, 32'h7);
		settle;
		cmp({code, tact}, {8'h00, 1'b1});
		wreg(`DFAM_REG_CTRL, 32'h3);
	endtask : t_tune
	// Remote operation and the linear scaling of both inputs.
	task t_scale;
		logic [11:0] vin[3] = '{12'h000, 12'h800, 12'hfff};
		logic [15:0] vex[3] = '{16'h0064, 16'h0226, 16'h03e7};
		wreg(`DFAM_REG_CTRL, 32'h0);
		@(posedge clk) tr <= 1'b1;
		wreg(`DFAM_REG_GAIN1, 32'h3e8);
		wreg(`DFAM_REG_BIAS1, 32'h64);
		settle;
		cmp({lri, run}, {1'b0, 1'b1});
		for (int i = 0; i < 3; i++) begin
			// first input stays within its voltage span
			@(posedge clk) va <= vin[i];
			settle;
			cmp(fref, vex[i]);
		end
		@(posedge clk) begin
			va  <= 12'h000;
			vcs <= 1'b1;
			ca  <= 12'h333;
		end
		wreg(`DFAM_REG_GAIN2, 32'h7d0);
		wreg(`DFAM_REG_IN2CFG, 32'h2);
		settle;
		cmp(fref, 16'h0064);
		@(posedge clk) ca <= 12'hfff;
		settle;
		cmp(fref, 16'h0833);
		wreg(`DFAM_REG_IN2CFG, 32'h3);
		@(posedge clk) ca <= 12'h800;
		settle;
		cmp(fref, 16'h044c);
	endtask : t_scale
	// Cuts a hang short well after the expected run length.
	initial begin
		#(5000 * 100);
		n_fail++;
		conclude;
	end
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset;
		t_fault;
		t_minor;
		t_oper;
		t_tune;
		t_scale;
		conclude;
	end
endmodule : testbench
